// File: inc/cdp_regs.vh
// Register map, field positions, encodings and timing constants of the channel block.
`ifndef CDP_REGS_VH
`define CDP_REGS_VH

// Byte addresses on the register bus.
`define CDP_ADDR_W 6
`define CDP_A_SVC_REQ 6'h00
`define CDP_A_RX_STATUS 6'h04
`define CDP_A_FRAME_OPT 6'h08
`define CDP_A_SRQ_EN 6'h0c
`define CDP_A_EVT_STATUS 6'h10
`define CDP_A_EVT_MASK 6'h14
`define CDP_A_RX_PERIOD 6'h18
`define CDP_A_RX_THRESH 6'h1c
`define CDP_A_VECTOR 6'h20

// Reset values.
`define CDP_RST_BYTE 8'h00
`define CDP_RST_THRESH 4'h8
`define CDP_FIFO_EMPTY 4'h0
`define CDP_ZERO8 8'h00
`define CDP_ZERO32 32'h00000000

// Service request enable fields; the unused positions are not stored.
`define CDP_SRQ_EN_MASK 8'h17
`define CDP_SRQ_RX 4
`define CDP_SRQ_TX_FIFO_EMPTY_REQUEST_ENABLE 2
`define CDP_SRQ_TX_SHIFT_EMPTY_REQUEST_ENABLE 1
`define CDP_SRQ_NO_NEW_DATA_TIMEOUT_ENABLE 0

// Frame option fields.
`define CDP_OPT_ODD 7
`define CDP_OPT_PMODE 6:5
`define CDP_OPT_IGNORE 4
`define CDP_OPT_STOP 3:2
`define CDP_OPT_LEN 1:0

// Parity mode encodings.
`define CDP_PM_NONE 2'b00
`define CDP_PM_FORCE 2'b01
`define CDP_PM_NORMAL 2'b10

// Character length encodings and resulting bit counts.
`define CDP_LEN_5 2'b00
`define CDP_LEN_6 2'b01
`define CDP_LEN_7 2'b10
`define CDP_BITS_5 4'h5
`define CDP_BITS_6 4'h6
`define CDP_BITS_7 4'h7
`define CDP_BITS_8 4'h8

// Service request register and receive status bits.
`define CDP_SVR_RX 0
`define CDP_SVR_TX 1
`define CDP_SVR_RXEXC 2
`define CDP_RECEIVE_DATA_STATUS_REG_NO_NEW_DATA_TIMEOUT_ENABLE 7
`define CDP_RECEIVE_DATA_STATUS_REG_PERR 0

// Sticky event status bits.
`define CDP_EV_RXTO 0
`define CDP_EV_NO_NEW_DATA_TIMEOUT_ENABLE 1
`define CDP_EV_PERR 2
`define CDP_EV_TXEMPTY 3
`define CDP_EV_MASK 8'h0f

// Vector type codes.
`define CDP_VT_NONE 3'h0
`define CDP_VT_TX 3'h2
`define CDP_VT_RX 3'h3
`define CDP_VT_RXEXC 3'h7

// Timeout unit: period register counts in microseconds.
`define CDP_CLK_NS 10
`define CDP_UNIT_NS 1000
`define CDP_UNIT_CYC (`CDP_UNIT_NS / `CDP_CLK_NS)
`define CDP_PRE_W 7
// Last prescaler count of a unit, one unit being a hundred clock cycles.
`define CDP_UNIT_LAST 7'h63

`endif

// File: rtl/cdp_parity.v
// Parity of a character of five to eight bits, odd or even.
`timescale 1ns/100ps
`default_nettype none
`include "cdp_regs.vh"

module cdp_parity (
  // Character
  input wire [7:0] data,
  input wire [1:0] len_sel,
  // Sense
  input wire odd,
  // Result
  output reg parity
);

  reg [7:0] masked;

  always @* begin
    case (len_sel)
      `CDP_LEN_5: masked = {3'h0, data[4:0]};
      `CDP_LEN_6: masked = {2'h0, data[5:0]};
      `CDP_LEN_7: masked = {1'h0, data[6:0]};
      default: masked = data;
    endcase
    // Odd parity makes the total number of ones odd.
    parity = (^masked) ^ odd;
  end

endmodule // cdp_parity

`default_nettype wire

// File: rtl/cdp_channel.v
// Channel service request enables, framing options and request posting.
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
`include "cdp_regs.vh"

// How it works
// R1 - With the receive enable set, a receive request is posted while characters are held and the fifo has reached its threshold or the receive timeout has run out.
// R2 - With the fifo-empty enable set, a transmit request is posted while the transmit fifo is empty, two characters still being in flight.
// R3 - With the shift-empty enable set, a transmit request is posted while the transmit shift register is empty.
// R4 - Software ending a transfer sets the shift-empty enable and clears the fifo-empty enable to learn when the last character has left.
// R5 - With the no-new-data enable set, a receive exception is posted when the fifo has drained and no character arrives within the timeout period.
// R6 - A no-new-data exception shows the receive exception code in the vector type bits and carries no data.
// R7 - Bit 7 of the receive data status register marks a pending exception as a no-new-data timeout.
// R8 - The parity type bit picks odd parity when one and even parity when zero for generation and checking.
// R9 - The parity mode field gives no parity, forced parity, normal parity or unused for both directions.
// R10 - With ignore parity set, incoming parity is disregarded and no exception is raised for bad parity.
// R11 - The stop length field sets the stop length in bit times, zero giving one stop bit.
// R12 - The character length field gives five to eight bits for both directions.
// R13 - Each enable governs one request type, and posted requests show in the service request register and the active-low request pin.
// R14 - Software writes zero to the unused bits of the service request enable register.
module cdp_channel (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Avalon-MM slave
  input wire [`CDP_ADDR_W-1:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output reg waitrequest,
  // Receive datapath status
  input wire [3:0] rx_fifo_count,
  input wire rx_char_valid,
  input wire [7:0] rx_char_data,
  input wire rx_char_parity,
  // Transmit datapath status
  input wire tx_fifo_empty,
  input wire tx_shift_empty,
  input wire [7:0] tx_char_data,
  // Framing settings to the datapath
  output reg [3:0] char_bits_q,
  output reg [1:0] stop_sel_q,
  output reg parity_on_q,
  output reg parity_forced_q,
  output reg tx_parity_bit_q,
  // Requests
  output reg [2:0] vector_type_bits_q,
  output reg service_request_pin_n,
  output reg irq_q
);

  // Registers.
  reg [7:0] opt_q;
  reg [7:0] srq_en_q;
  reg [7:0] period_q;
  reg [3:0] thresh_q;
  reg [7:0] ev_q;
  reg [7:0] ev_d;
  reg [7:0] mask_q;
  reg no_new_data_timeout_enable_pend_q;
  reg no_new_data_timeout_enable_pend_d;
  reg perr_pend_q;
  reg perr_pend_d;
  reg rxto_q;
  reg rxto_d;
  reg no_new_data_timeout_enable_armed_q;
  reg [`CDP_PRE_W-1:0] pre_q;
  reg [7:0] tmo_q;
  reg [3:0] cnt_prev_q;
  reg txe_prev_q;
  reg [2:0] svr;
  reg [2:0] vt;

  // Bus handshake terms.
  wire wr_done = write & ~waitrequest;
  wire rd_done = read & ~waitrequest;
  wire rd_status = rd_done & (address == `CDP_A_RX_STATUS);

  // Character length decode.
  function [3:0] len_bits;
    input [1:0] sel;
    begin
      case (sel)
        `CDP_LEN_5: len_bits = `CDP_BITS_5;
        `CDP_LEN_6: len_bits = `CDP_BITS_6;
        `CDP_LEN_7: len_bits = `CDP_BITS_7;
        default: len_bits = `CDP_BITS_8;
      endcase
    end
  endfunction

  // Parity of each direction from its own instance of the parity generator.
  wire rx_par;
  wire tx_par;
  cdp_parity u_rx_par (
    .data(rx_char_data),
    .len_sel(opt_q[`CDP_OPT_LEN]),
    .odd(opt_q[`CDP_OPT_ODD]),
    .parity(rx_par)
  );
  cdp_parity u_tx_par (
    .data(tx_char_data),
    .len_sel(opt_q[`CDP_OPT_LEN]),
    .odd(opt_q[`CDP_OPT_ODD]),
    .parity(tx_par)
  );

  wire [1:0] pmode = opt_q[`CDP_OPT_PMODE];
  wire mode_force = (pmode == `CDP_PM_FORCE);
  wire mode_normal = (pmode == `CDP_PM_NORMAL);
  // Forced parity is one for odd and zero for even.
  wire tx_bit = mode_force ? opt_q[`CDP_OPT_ODD] : tx_par; // R8 R9
  wire rx_bad = (mode_force & (rx_char_parity != opt_q[`CDP_OPT_ODD])) |
                (mode_normal & (rx_char_parity != rx_par)); // R8 R9
  // Ignore mode swallows the error before it can become an exception.
  wire perr_evt = rx_char_valid & rx_bad & ~opt_q[`CDP_OPT_IGNORE]; // R10

  // Timeout timer shared by the threshold timeout and the no-new-data timeout.
  wire fifo_held = (rx_fifo_count != `CDP_FIFO_EMPTY);
  wire drained = ~fifo_held & (cnt_prev_q != `CDP_FIFO_EMPTY);
  wire timing = (fifo_held | no_new_data_timeout_enable_armed_q) & (period_q != `CDP_ZERO8);
  wire unit_tick = (pre_q == `CDP_UNIT_LAST);
  wire expire = timing & unit_tick & (tmo_q == period_q - 8'h01);
  wire rxto_evt = expire & fifo_held;
  wire no_new_data_timeout_enable_evt = expire & ~fifo_held & no_new_data_timeout_enable_armed_q; // R5
  wire txe_evt = tx_fifo_empty & ~txe_prev_q;

  // Prescaler and period counter of the shared timer.
  always @(posedge clk) begin
    if (rst) begin
      pre_q <= {`CDP_PRE_W{1'b0}};
      tmo_q <= `CDP_ZERO8;
    end else if (rx_char_valid | drained | ~timing) begin
      // A new character or a drain restarts the wait from zero.
      pre_q <= {`CDP_PRE_W{1'b0}};
      tmo_q <= `CDP_ZERO8;
    end else if (unit_tick) begin
      pre_q <= {`CDP_PRE_W{1'b0}};
      tmo_q <= expire ? `CDP_ZERO8 : tmo_q + 8'h01;
    end else begin
      pre_q <= pre_q + {{(`CDP_PRE_W-1){1'b0}}, 1'b1};
    end
  end

  // Previous levels for the edge detectors.
  // The fifo-empty detector idles high, since an idle transmitter has an empty fifo.
  always @(posedge clk) begin
    if (rst) begin
      cnt_prev_q <= `CDP_FIFO_EMPTY;
      txe_prev_q <= 1'b1;
    end else begin
      cnt_prev_q <= rx_fifo_count;
      txe_prev_q <= tx_fifo_empty;
    end
  end

  // Only a drain arms the wait, so an empty fifo after reset never times out.
  always @(posedge clk) begin
    if (rst) begin
      no_new_data_timeout_enable_armed_q <= 1'b0;
    end else if (rx_char_valid | no_new_data_timeout_enable_evt) begin
      no_new_data_timeout_enable_armed_q <= 1'b0;
    end else if (drained) begin
      no_new_data_timeout_enable_armed_q <= 1'b1; // R5
    end
  end

  // Pending flags and sticky events; a set in the clearing cycle wins.
  always @* begin
    rxto_d = rxto_q;
    if (~fifo_held | rx_char_valid) begin
      rxto_d = 1'b0;
    end
    if (rxto_evt) begin
      rxto_d = 1'b1;
    end
    no_new_data_timeout_enable_pend_d = no_new_data_timeout_enable_pend_q;
    if (rd_status | rx_char_valid) begin
      no_new_data_timeout_enable_pend_d = 1'b0;
    end
    if (no_new_data_timeout_enable_evt & srq_en_q[`CDP_SRQ_NO_NEW_DATA_TIMEOUT_ENABLE]) begin
      no_new_data_timeout_enable_pend_d = 1'b1; // R5 R7
    end
    perr_pend_d = perr_pend_q;
    if (rd_status) begin
      perr_pend_d = 1'b0;
    end
    if (perr_evt) begin
      perr_pend_d = 1'b1; // R10
    end
    ev_d = ev_q;
    if (wr_done & (address == `CDP_A_EVT_STATUS)) begin
      ev_d = ev_q & ~writedata[7:0];
    end
    ev_d[`CDP_EV_RXTO] = ev_d[`CDP_EV_RXTO] | rxto_evt;
    ev_d[`CDP_EV_NO_NEW_DATA_TIMEOUT_ENABLE] = ev_d[`CDP_EV_NO_NEW_DATA_TIMEOUT_ENABLE] | no_new_data_timeout_enable_evt;
    ev_d[`CDP_EV_PERR] = ev_d[`CDP_EV_PERR] | perr_evt;
    ev_d[`CDP_EV_TXEMPTY] = ev_d[`CDP_EV_TXEMPTY] | txe_evt;
  end

  // Request posting, one enable to one request type.
  always @* begin
    svr = 3'h0;
    svr[`CDP_SVR_RX] = srq_en_q[`CDP_SRQ_RX] & fifo_held &
                       ((rx_fifo_count >= thresh_q) | rxto_q); // R1 R13
    svr[`CDP_SVR_TX] = (srq_en_q[`CDP_SRQ_TX_FIFO_EMPTY_REQUEST_ENABLE] & tx_fifo_empty) |
                       (srq_en_q[`CDP_SRQ_TX_SHIFT_EMPTY_REQUEST_ENABLE] & tx_shift_empty); // R2 R3 R4 R13
    svr[`CDP_SVR_RXEXC] = no_new_data_timeout_enable_pend_q | perr_pend_q; // R13
    // Exceptions come first, since they carry no data and must not be
    // mistaken for a data request by the service routine.
    if (svr[`CDP_SVR_RXEXC]) begin
      vt = `CDP_VT_RXEXC; // R6
    end else if (svr[`CDP_SVR_RX]) begin
      vt = `CDP_VT_RX;
    end else if (svr[`CDP_SVR_TX]) begin
      vt = `CDP_VT_TX;
    end else begin
      vt = `CDP_VT_NONE;
    end
  end

  // Software-written registers.
  always @(posedge clk) begin
    if (rst) begin
      opt_q <= `CDP_RST_BYTE;
      srq_en_q <= `CDP_RST_BYTE;
      period_q <= `CDP_RST_BYTE;
      thresh_q <= `CDP_RST_THRESH;
      mask_q <= `CDP_RST_BYTE;
    end else if (wr_done) begin
      case (address)
        `CDP_A_FRAME_OPT: opt_q <= writedata[7:0];
        // Unused enable positions are dropped in case software sets them.
        `CDP_A_SRQ_EN: srq_en_q <= writedata[7:0] & `CDP_SRQ_EN_MASK; // R14
        `CDP_A_EVT_MASK: mask_q <= writedata[7:0] & `CDP_EV_MASK;
        `CDP_A_RX_PERIOD: period_q <= writedata[7:0];
        `CDP_A_RX_THRESH: thresh_q <= writedata[3:0];
        default: ;
      endcase
    end
  end

  // Flags and registered outputs.
  // The pin and the vector are registered together so that they never disagree.
  always @(posedge clk) begin
    if (rst) begin
      ev_q <= `CDP_RST_BYTE;
      rxto_q <= 1'b0;
      no_new_data_timeout_enable_pend_q <= 1'b0;
      perr_pend_q <= 1'b0;
      char_bits_q <= `CDP_BITS_5;
      stop_sel_q <= 2'b00;
      parity_on_q <= 1'b0;
      parity_forced_q <= 1'b0;
      tx_parity_bit_q <= 1'b0;
      vector_type_bits_q <= `CDP_VT_NONE;
      service_request_pin_n <= 1'b1;
      irq_q <= 1'b0;
    end else begin
      ev_q <= ev_d & `CDP_EV_MASK;
      rxto_q <= rxto_d;
      no_new_data_timeout_enable_pend_q <= no_new_data_timeout_enable_pend_d;
      perr_pend_q <= perr_pend_d;
      char_bits_q <= len_bits(opt_q[`CDP_OPT_LEN]); // R12
      stop_sel_q <= opt_q[`CDP_OPT_STOP]; // R11
      parity_on_q <= mode_force | mode_normal; // R9
      parity_forced_q <= mode_force; // R9
      tx_parity_bit_q <= tx_bit; // R8
      vector_type_bits_q <= vt; // R6
      service_request_pin_n <= ~(|svr); // R13
      irq_q <= |(ev_d & mask_q);
    end
  end

  // Bus slave: each access is answered in its second cycle.
  always @(posedge clk) begin
    if (rst) begin
      waitrequest <= 1'b1;
      readdata <= `CDP_ZERO32;
    end else if ((read | write) & waitrequest) begin
      waitrequest <= 1'b0;
      case (address)
        `CDP_A_SVC_REQ: readdata <= {29'h0, svr};
        `CDP_A_RX_STATUS: readdata <= {24'h0, no_new_data_timeout_enable_pend_q, 6'h0, perr_pend_q}; // R7
        `CDP_A_FRAME_OPT: readdata <= {24'h0, opt_q};
        `CDP_A_SRQ_EN: readdata <= {24'h0, srq_en_q};
        `CDP_A_EVT_STATUS: readdata <= {24'h0, ev_q};
        `CDP_A_EVT_MASK: readdata <= {24'h0, mask_q};
        `CDP_A_RX_PERIOD: readdata <= {24'h0, period_q};
        `CDP_A_RX_THRESH: readdata <= {28'h0, thresh_q};
        `CDP_A_VECTOR: readdata <= {29'h0, vt}; // R6
        default: readdata <= `CDP_ZERO32;
      endcase
    end else begin
      waitrequest <= 1'b1;
    end
  end

endmodule // cdp_channel

`default_nettype wire

// File: bench/cdp_chk.sv
// Port-level assertions for the channel block.
`timescale 1ns/100ps
`default_nettype none
`include "cdp_regs.vh"
module cdp_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic waitrequest,
  // Transmit status
  input wire logic tx_fifo_empty,
  input wire logic tx_shift_empty,
  input wire logic [7:0] tx_char_data,
  // Outputs
  input wire logic [3:0] char_bits_q,
  input wire logic [1:0] stop_sel_q,
  input wire logic parity_on_q,
  input wire logic parity_forced_q,
  input wire logic tx_parity_bit_q,
  input wire logic [2:0] vector_type_bits_q,
  input wire logic service_request_pin_n
);
  // Shadow copies of the two option registers, taken where a write completes.
  logic [7:0] opt_q;
  logic [7:0] en_q;
  wire wdone = write && !waitrequest;
  always_ff @(posedge clk) begin
    if (rst) begin
      opt_q <= 8'h00;
      en_q <= 8'h00;
    end else if (wdone && address == `CDP_A_FRAME_OPT) begin
      opt_q <= writedata[7:0];
    end else if (wdone && address == `CDP_A_SRQ_EN) begin
      en_q <= writedata[7:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Outputs lag by a register stage, so causes must stand for two edges first.
  sequence s_hold;
    $stable({opt_q, en_q, tx_char_data, tx_fifo_empty, tx_shift_empty})[*2];
  endsequence
  AST_ONE_WAIT: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("no answer after one wait cycle");
  AST_CHAR_LEN: assert property (s_hold |-> char_bits_q == 4'h5 + {2'b00, opt_q[1:0]})
    else $error("character length wrong");
  AST_STOP_LEN: assert property (s_hold |-> stop_sel_q == opt_q[3:2])
    else $error("stop length wrong");
  AST_PAR_ON: assert property (s_hold |-> parity_on_q == (opt_q[6:5] == 2'b01 || opt_q[6:5] == 2'b10))
    else $error("parity enable wrong");
  AST_PAR_FORCE: assert property (s_hold ##0 opt_q[6:5] == 2'b01 |-> parity_forced_q && tx_parity_bit_q == opt_q[7])
    else $error("forced parity wrong");
  AST_PAR_NORM: assert property (s_hold ##0 opt_q[6:5] == 2'b10 && opt_q[1:0] == 2'b11 |-> tx_parity_bit_q == (^tx_char_data ^ opt_q[7]))
    else $error("parity bit wrong");
  AST_TX_FIFO: assert property (s_hold ##0 en_q[2] && tx_fifo_empty |-> !service_request_pin_n)
    else $error("fifo empty request missing");
  AST_TX_SHIFT: assert property (s_hold ##0 en_q[1] && tx_shift_empty |-> !service_request_pin_n)
    else $error("shift empty request missing");
  AST_VEC_PIN: assert property (service_request_pin_n == (vector_type_bits_q == `CDP_VT_NONE))
    else $error("pin and vector disagree");
endmodule // cdp_chk
bind cdp_channel cdp_chk u_chk (.clk(clk), .rst(rst), .address(address), .read(read),
  .write(write), .writedata(writedata), .waitrequest(waitrequest),
  .tx_fifo_empty(tx_fifo_empty), .tx_shift_empty(tx_shift_empty),
  .tx_char_data(tx_char_data), .char_bits_q(char_bits_q), .stop_sel_q(stop_sel_q),
  .parity_on_q(parity_on_q), .parity_forced_q(parity_forced_q),
  .tx_parity_bit_q(tx_parity_bit_q), .vector_type_bits_q(vector_type_bits_q),
  .service_request_pin_n(service_request_pin_n));
`default_nettype wire

// File: bench/cdp_host.sv
// Host processor model that makes register accesses.
`timescale 1ns/100ps
`default_nettype none
`include "cdp_regs.vh"
module cdp_host (
  // Clock
  input wire logic clk,
  // Register bus
  input wire logic waitrequest,
  output logic [5:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata
);
  initial begin
    address = 6'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
  end
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    address <= a;
    writedata <= {24'h000000, (a == `CDP_A_SRQ_EN) ? (d & `CDP_SRQ_EN_MASK) : d};
    read <= !w;
    write <= w;
    @(posedge clk);
    while (waitrequest) @(posedge clk);
    read <= 1'b0;
    write <= 1'b0;
    // Released lines show garbage so that a stale value is never mistaken for data.
    address <= ~a;
    writedata <= ~writedata;
  endtask
  task automatic end_tx;
    acc(1'b1, `CDP_A_SRQ_EN, 8'h02);
  endtask
endmodule // cdp_host
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the channel block.
`timescale 1ns/100ps
`default_nettype none
`include "cdp_regs.vh"
module tb;
  logic clk, rst, read, write, waitrequest, rx_char_valid, rx_char_parity;
  logic tx_fifo_empty, tx_shift_empty, parity_on_q, parity_forced_q, tx_parity_bit_q;
  logic service_request_pin_n, irq_q;
  logic [5:0] address;
  logic [31:0] writedata, readdata;
  logic [3:0] rx_fifo_count, char_bits_q;
  logic [7:0] rx_char_data, tx_char_data, d;
  logic [1:0] stop_sel_q;
  logic [2:0] vector_type_bits_q;
  logic [7:0] exp_q[$];
  int fail_count = 0, num_checks = 0, cyc = 0, i;
  integer seed = 32'hc119;
  cdp_channel uut (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .rx_fifo_count(rx_fifo_count), .rx_char_valid(rx_char_valid),
    .rx_char_data(rx_char_data), .rx_char_parity(rx_char_parity),
    .tx_fifo_empty(tx_fifo_empty), .tx_shift_empty(tx_shift_empty),
    .tx_char_data(tx_char_data), .char_bits_q(char_bits_q), .stop_sel_q(stop_sel_q),
    .parity_on_q(parity_on_q), .parity_forced_q(parity_forced_q),
    .tx_parity_bit_q(tx_parity_bit_q), .vector_type_bits_q(vector_type_bits_q),
    .service_request_pin_n(service_request_pin_n), .irq_q(irq_q));
  cdp_host host (.clk(clk), .waitrequest(waitrequest), .address(address), .read(read),
    .write(write), .writedata(writedata));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.acc(1'b0, a, 8'h00);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    host.acc(1'b1, a, v);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Read data is compared at the edge that completes the access.
  always @(posedge clk) begin
    cyc++;
    if (read && !waitrequest) check(readdata[7:0], exp_q.pop_front());
    if (cyc == 5000) begin
      fail_count++;
      complete_run;
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst, rx_char_valid, rx_char_parity, tx_fifo_empty, tx_shift_empty} = 5'b10000;
    {rx_fifo_count, rx_char_data, tx_char_data} = 20'h00000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(`CDP_A_RX_THRESH, 8'h08);
    rd(6'h3c, 8'h00);
    for (i = 0; i < 8; i++) begin
      d = $random(seed);
      tx_char_data <= $random(seed);
      wr(`CDP_A_FRAME_OPT, d);
      rd(`CDP_A_FRAME_OPT, d);
      check({4'h0, char_bits_q}, 8'h05 + {6'h00, d[1:0]});
      check({6'h00, stop_sel_q}, {6'h00, d[3:2]});
    end
    tx_fifo_empty <= 1'b1;
    wr(`CDP_A_SRQ_EN, 8'h04);
    rd(`CDP_A_SVC_REQ, 8'h02);
    rd(`CDP_A_VECTOR, 8'h02);
    check({7'h00, service_request_pin_n}, 8'h00);
    host.end_tx();
    rd(`CDP_A_SVC_REQ, 8'h00);
    tx_shift_empty <= 1'b1;
    rd(`CDP_A_SVC_REQ, 8'h02);
    tx_shift_empty <= 1'b0;
    wr(`CDP_A_SRQ_EN, 8'h10);
    wr(`CDP_A_RX_THRESH, 8'h02);
    rx_fifo_count <= 4'h1;
    rd(`CDP_A_SVC_REQ, 8'h00);
    rx_fifo_count <= 4'h2;
    rd(`CDP_A_SVC_REQ, 8'h01);
    wr(`CDP_A_SRQ_EN, 8'h01);
    wr(`CDP_A_RX_PERIOD, 8'h01);
    rx_fifo_count <= 4'h0;
    // One period unit is 100 cycles; wait past it.
    repeat (150) @(posedge clk);
    rd(`CDP_A_SVC_REQ, 8'h04);
    rd(`CDP_A_VECTOR, 8'h07);
    check({5'h00, vector_type_bits_q}, 8'h07);
    check({7'h00, irq_q}, 8'h00);
    wr(`CDP_A_EVT_MASK, 8'h02);
    rd(`CDP_A_RX_STATUS, 8'h80);
    check({7'h00, irq_q}, 8'h01);
    wr(`CDP_A_EVT_STATUS, 8'h02);
    rd(`CDP_A_RX_STATUS, 8'h00);
    check({7'h00, irq_q}, 8'h00);
    // One character below the threshold posts a request only once the timeout runs out.
    rx_fifo_count <= 4'h1;
    wr(`CDP_A_SRQ_EN, 8'h10);
    rd(`CDP_A_SVC_REQ, 8'h00);
    repeat (150) @(posedge clk);
    rd(`CDP_A_SVC_REQ, 8'h01);
    rx_char_data <= 8'h01;
    for (i = 0; i < 2; i++) begin
      wr(`CDP_A_FRAME_OPT, (i == 1) ? 8'h53 : 8'h43);
      rx_char_valid <= 1'b1;
      @(posedge clk);
      rx_char_valid <= 1'b0;
      rd(`CDP_A_RX_STATUS, (i == 1) ? 8'h00 : 8'h01);
    end
    complete_run;
  end
endmodule // tb
`default_nettype wire
